// *** rtl/rbc_config_bank.sv ***
// Purpose: configuration register bank of the sub-GHz radio and baseband
// Assumes: single clock, host bus with read data one cycle after strobe
// Notes:   channel settings are applied as one set on the high-byte write
//
// Overview of operation
// - center frequency word counts in 25 kHz steps.
// - channel spacing code 0x30 means 1.2 MHz.
// - channel low byte first; high-byte write applies the channel.
// - high-byte write applies the channel even with unchanged value.
// - energy duration code 0x7A selects 960 us averaging.
// - PHY type value 2 selects MR-OFDM; other fields keep reset.
// - coding scheme value 3 selects 800 kb/s.
// - AGC averaging and input reset 0, target level resets 3.
// - reset restores all defaults and the transceiver-off state.
// - OFDM option field resets to option 1.
// - random value register reads changing content.
`timescale 1ns/1ps

module rbc_config_bank #(
  parameter logic [7:0] RST_PHY_CONTROL = 8'h54
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  input  wire rbc_pkg::rbc_bus_req_t bus_req_i,
  output logic [7:0]                 rdata_o,
  output rbc_pkg::rbc_channel_t      channel_o,
  output logic                       channel_update_o,
  output logic [7:0]                 radio_irq_mask_o,
  output logic [7:0]                 bb_irq_mask_o,
  output logic [1:0]                 phy_type_o,
  output logic [2:0]                 coding_scheme_o,
  output logic [1:0]                 ofdm_option_o,
  output logic [7:0]                 ed_duration_o,
  output logic                       transceiver_off_o
);
  import rbc_pkg::*;

  logic [7:0]     radio_irq_mask_ff;
  logic [7:0]     channel_spacing_ff;
  logic [7:0]     cfreq_low_ff;
  logic [7:0]     cfreq_high_ff;
  logic [7:0]     chan_low_ff;
  logic [7:0]     chan_high_ff;
  logic [7:0]     rx_bw_ff;
  logic [7:0]     rx_dfe_ff;
  logic [7:0]     agc_ctrl_ff;
  logic [7:0]     agc_target_ff;
  logic [7:0]     ed_duration_ff;
  logic [7:0]     tx_cut_ff;
  logic [7:0]     tx_dfe_ff;
  logic [7:0]     pac_ff;
  logic [7:0]     bb_irq_mask_ff;
  logic [7:0]     phy_control_ff;
  logic [7:0]     ofdm_cfg_ff;
  logic [7:0]     ofdm_tx_hdr_ff;
  logic [7:0]     lfsr_ff;
  logic [7:0]     rdata_ff;
  logic [7:0]     nxt_rdata;
  rbc_channel_t   channel_ff;
  logic           update_ff;
  rbc_trx_state_t state_ff;
  logic           trx_off_ff;
  logic           wr;

  assign wr = bus_req_i.wr;

  // plain storage registers; reset restores defaults
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      radio_irq_mask_ff  <= RST_ZERO;
      channel_spacing_ff <= RST_ZERO;
      cfreq_low_ff       <= RST_ZERO;
      cfreq_high_ff      <= RST_ZERO;
      chan_low_ff        <= RST_ZERO;
      chan_high_ff       <= RST_ZERO;
      rx_bw_ff           <= RST_ZERO;
      rx_dfe_ff          <= RST_ZERO;
      ed_duration_ff     <= RST_ZERO;
      tx_cut_ff          <= RST_ZERO;
      tx_dfe_ff          <= RST_ZERO;
      pac_ff             <= RST_ZERO;
      bb_irq_mask_ff     <= RST_ZERO;
      ofdm_tx_hdr_ff     <= RST_ZERO;
    end else if (wr) begin
      case (bus_req_i.addr)
        OFS_RADIO_IRQ_MASK:   radio_irq_mask_ff  <= bus_req_i.wdata;
        OFS_CHANNEL_SPACING:  channel_spacing_ff <= bus_req_i.wdata;
        OFS_CENTER_FREQ_LOW:  cfreq_low_ff       <= bus_req_i.wdata;
        OFS_CENTER_FREQ_HIGH: cfreq_high_ff      <= bus_req_i.wdata;
        OFS_CHANNEL_NUM_LOW:  chan_low_ff        <= bus_req_i.wdata;
        OFS_CHANNEL_NUM_HIGH: chan_high_ff       <= bus_req_i.wdata;
        OFS_RX_BW_CTRL:       rx_bw_ff           <= bus_req_i.wdata;
        OFS_RX_DFE:           rx_dfe_ff          <= bus_req_i.wdata;
        OFS_ED_DURATION:      ed_duration_ff     <= bus_req_i.wdata;
        OFS_TX_FILTER_CUTOFF: tx_cut_ff          <= bus_req_i.wdata;
        OFS_TX_DFE:           tx_dfe_ff          <= bus_req_i.wdata;
        OFS_POWER_AMP_CONFIG: pac_ff             <= bus_req_i.wdata;
        OFS_BB_IRQ_MASK:      bb_irq_mask_ff     <= bus_req_i.wdata;
        OFS_OFDM_TX_HEADER:   ofdm_tx_hdr_ff     <= bus_req_i.wdata;
        default: ;
      endcase
    end
  end

  // agc target and phy type have non-zero defaults; agc control and ofdm option reset to zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      agc_ctrl_ff    <= RST_AGC_CTRL;
      agc_target_ff  <= RST_AGC_TARGET;
      phy_control_ff <= RST_PHY_CONTROL;
      ofdm_cfg_ff    <= RST_OFDM_CFG;     // option 1
    end else if (wr) begin
      case (bus_req_i.addr)
        OFS_AGC_CTRL:    agc_ctrl_ff    <= bus_req_i.wdata;
        OFS_AGC_TARGET:  agc_target_ff  <= bus_req_i.wdata;
        OFS_PHY_CONTROL: phy_control_ff <= bus_req_i.wdata;
        OFS_OFDM_CONFIG: ofdm_cfg_ff    <= bus_req_i.wdata;
        default: ;
      endcase
    end
  end

  // channel set applied only on the high-byte write, equal value or not;
  // low-byte writes alone never move the synthesiser
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_ff.center_freq_value <= RST_CFREQ;
      channel_ff.channel_spacing   <= RST_ZERO;
      channel_ff.channel_number    <= RST_CHAN_NUM;
      update_ff                    <= 1'b0;
    end else begin
      update_ff <= 1'b0;
      if (wr && bus_req_i.addr == OFS_CHANNEL_NUM_HIGH) begin
        // 25 kHz units, high byte above low
        channel_ff.center_freq_value <= {cfreq_high_ff, cfreq_low_ff};
        channel_ff.channel_spacing   <= channel_spacing_ff;
        channel_ff.channel_number    <= {bus_req_i.wdata, chan_low_ff};
        update_ff                    <= 1'b1;
      end
    end
  end

  // free-running lfsr stands in for the noise source
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr_ff <= RST_LFSR;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0],
                  lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end
  end

  // reset enters transceiver-off; first channel update leaves it
  // off flag kept as its own flop so the pin never sees decode glitches
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff   <= RBC_TRX_OFF;
      trx_off_ff <= 1'b1;
    end else begin
      case (state_ff)
        RBC_TRX_OFF: begin
          if (update_ff) begin
            state_ff   <= RBC_TRX_CFG;
            trx_off_ff <= 1'b0;
          end
        end
        RBC_TRX_CFG: begin
          state_ff   <= RBC_TRX_CFG;
          trx_off_ff <= 1'b0;
        end
        default: begin
          state_ff   <= RBC_TRX_OFF;
          trx_off_ff <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    nxt_rdata = RST_ZERO;
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        OFS_RADIO_IRQ_MASK:   nxt_rdata = radio_irq_mask_ff;
        OFS_CHANNEL_SPACING:  nxt_rdata = channel_spacing_ff;
        OFS_CENTER_FREQ_LOW:  nxt_rdata = cfreq_low_ff;
        OFS_CENTER_FREQ_HIGH: nxt_rdata = cfreq_high_ff;
        OFS_CHANNEL_NUM_LOW:  nxt_rdata = chan_low_ff;
        OFS_CHANNEL_NUM_HIGH: nxt_rdata = chan_high_ff;
        OFS_RX_BW_CTRL:       nxt_rdata = rx_bw_ff;
        OFS_RX_DFE:           nxt_rdata = rx_dfe_ff;
        OFS_AGC_CTRL:         nxt_rdata = agc_ctrl_ff;
        OFS_AGC_TARGET:       nxt_rdata = agc_target_ff;
        OFS_ED_DURATION:      nxt_rdata = ed_duration_ff;
        OFS_RANDOM_VALUE:     nxt_rdata = lfsr_ff;
        OFS_TX_FILTER_CUTOFF: nxt_rdata = tx_cut_ff;
        OFS_TX_DFE:           nxt_rdata = tx_dfe_ff;
        OFS_POWER_AMP_CONFIG: nxt_rdata = pac_ff;
        OFS_STATE_STATUS:     nxt_rdata = {6'h00, state_ff};
        OFS_BB_IRQ_MASK:      nxt_rdata = bb_irq_mask_ff;
        OFS_PHY_CONTROL:      nxt_rdata = phy_control_ff;
        OFS_OFDM_CONFIG:      nxt_rdata = ofdm_cfg_ff;
        OFS_OFDM_TX_HEADER:   nxt_rdata = ofdm_tx_hdr_ff;
        default:              nxt_rdata = RST_ZERO;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= RST_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o           = rdata_ff;
  assign channel_o         = channel_ff;
  assign channel_update_o  = update_ff;
  assign radio_irq_mask_o  = radio_irq_mask_ff;
  assign bb_irq_mask_o     = bb_irq_mask_ff;
  assign phy_type_o        = phy_control_ff[PHY_TYPE_LSB +: 2];
  assign coding_scheme_o   = ofdm_tx_hdr_ff[MCS_LSB +: 3];
  assign ofdm_option_o     = ofdm_cfg_ff[OFDM_OPT_LSB +: 2];
  assign ed_duration_o     = ed_duration_ff;
  assign transceiver_off_o = trx_off_ff;

  property p_update_on_high_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_CHANNEL_NUM_HIGH) |=> update_ff;
  endproperty
  a_update_on_high_write: assert property (p_update_on_high_write)
    else $error("high-byte write did not trigger channel update");

  property p_no_update_on_low_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(wr && bus_req_i.addr == OFS_CHANNEL_NUM_HIGH) |=> !update_ff;
  endproperty
  a_no_update_on_low_write:
    assert property (p_no_update_on_low_write)
    else $error("channel update without high-byte write");

  property p_channel_number_pair;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      update_ff |-> channel_ff.channel_number[7:0] == chan_low_ff;
  endproperty
  a_channel_number_pair: assert property (p_channel_number_pair)
    else $error("applied channel low byte mismatch");

  property p_cfreq_bytes;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      update_ff |-> channel_ff.center_freq_value ==
                    {$past(cfreq_high_ff), $past(cfreq_low_ff)};
  endproperty
  a_cfreq_bytes: assert property (p_cfreq_bytes)
    else $error("center frequency word not assembled high over low");

  property p_spacing_applied;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      update_ff |-> channel_ff.channel_spacing == $past(channel_spacing_ff);
  endproperty
  a_spacing_applied: assert property (p_spacing_applied)
    else $error("spacing code not applied with channel");

  property p_reg_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(wr && bus_req_i.addr == OFS_POWER_AMP_CONFIG) |=> $stable(pac_ff);
  endproperty
  a_reg_holds: assert property (p_reg_holds)
    else $error("register changed without a write");

  property p_random_moves;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      1'b1 |=> lfsr_ff != $past(lfsr_ff);
  endproperty
  a_random_moves: assert property (p_random_moves)
    else $error("random value did not change");

  property p_read_timing;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (bus_req_i.rd && bus_req_i.addr == OFS_ED_DURATION && !wr)
        |=> rdata_ff == $past(ed_duration_ff);
  endproperty
  a_read_timing: assert property (p_read_timing)
    else $error("read data wrong one cycle after strobe");

  property p_off_until_update;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff == RBC_TRX_OFF && !update_ff) |=> state_ff == RBC_TRX_OFF;
  endproperty
  a_off_until_update: assert property (p_off_until_update)
    else $error("left transceiver-off without update");

  // register writes reach their outputs one edge later
  property p_radio_mask_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_RADIO_IRQ_MASK)
        |=> radio_irq_mask_o == $past(bus_req_i.wdata);
  endproperty
  a_radio_mask_write: assert property (p_radio_mask_write)
    else $error("radio interrupt mask write lost");

  property p_bb_mask_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_BB_IRQ_MASK)
        |=> bb_irq_mask_o == $past(bus_req_i.wdata);
  endproperty
  a_bb_mask_write: assert property (p_bb_mask_write)
    else $error("baseband interrupt mask write lost");

  property p_ed_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_ED_DURATION)
        |=> ed_duration_o == $past(bus_req_i.wdata);
  endproperty
  a_ed_write: assert property (p_ed_write)
    else $error("energy duration write lost");

  property p_mr_ofdm_select;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_PHY_CONTROL &&
       bus_req_i.wdata[PHY_TYPE_LSB +: 2] == PHY_MR_OFDM)
        |=> phy_type_o == PHY_MR_OFDM;
  endproperty
  a_mr_ofdm_select: assert property (p_mr_ofdm_select)
    else $error("phy type did not select mr-ofdm");

  property p_mcs_select;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr && bus_req_i.addr == OFS_OFDM_TX_HEADER)
        |=> coding_scheme_o == $past(bus_req_i.wdata[MCS_LSB +: 3]);
  endproperty
  a_mcs_select: assert property (p_mcs_select)
    else $error("coding scheme field not taken");

  // defaults must survive until software overwrites them
  property p_agc_ctrl_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(wr && bus_req_i.addr == OFS_AGC_CTRL) |=> $stable(agc_ctrl_ff);
  endproperty
  a_agc_ctrl_holds: assert property (p_agc_ctrl_holds)
    else $error("agc control changed without a write");

  property p_agc_target_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(wr && bus_req_i.addr == OFS_AGC_TARGET)
        |=> $stable(agc_target_ff);
  endproperty
  a_agc_target_holds: assert property (p_agc_target_holds)
    else $error("agc target changed without a write");

  property p_ofdm_opt_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(wr && bus_req_i.addr == OFS_OFDM_CONFIG)
        |=> $stable(ofdm_option_o);
  endproperty
  a_ofdm_opt_holds: assert property (p_ofdm_opt_holds)
    else $error("ofdm option changed without a write");

  property p_channel_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !update_ff |-> $stable(channel_ff);
  endproperty
  a_channel_holds: assert property (p_channel_holds)
    else $error("applied channel moved without update");

  property p_leave_off;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff == RBC_TRX_OFF && update_ff) |=> !transceiver_off_o;
  endproperty
  a_leave_off: assert property (p_leave_off)
    else $error("off flag stuck after channel update");

  property p_off_output;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff == RBC_TRX_OFF) |-> transceiver_off_o;
  endproperty
  a_off_output: assert property (p_off_output)
    else $error("off flag low in transceiver-off state");

  property p_rdata_idle_zero;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !bus_req_i.rd |=> rdata_o == RST_ZERO;
  endproperty
  a_rdata_idle_zero: assert property (p_rdata_idle_zero)
    else $error("read data not zero without a read");

endmodule

// *** rtl/rbc_pkg.sv ***
// Purpose: constants and types for the radio baseband configuration bank
// Assumes: 8-bit registers on a 10-bit byte address
// Notes:   reset values not given by the example are parameters of the top
package rbc_pkg;

  localparam int          ADDR_W = 10;
  localparam int          DATA_W = 8;

  localparam logic [9:0]  OFS_RADIO_IRQ_MASK    = 10'h100;
  localparam logic [9:0]  OFS_CHANNEL_SPACING   = 10'h104;
  localparam logic [9:0]  OFS_CENTER_FREQ_LOW   = 10'h105;
  localparam logic [9:0]  OFS_CENTER_FREQ_HIGH  = 10'h106;
  localparam logic [9:0]  OFS_CHANNEL_NUM_LOW   = 10'h107;
  localparam logic [9:0]  OFS_CHANNEL_NUM_HIGH  = 10'h108;
  localparam logic [9:0]  OFS_RX_BW_CTRL        = 10'h109;
  localparam logic [9:0]  OFS_RX_DFE            = 10'h10A;
  localparam logic [9:0]  OFS_AGC_CTRL          = 10'h10B;
  localparam logic [9:0]  OFS_AGC_TARGET        = 10'h10C;
  localparam logic [9:0]  OFS_ED_DURATION       = 10'h10F;
  localparam logic [9:0]  OFS_RANDOM_VALUE      = 10'h111;
  localparam logic [9:0]  OFS_TX_FILTER_CUTOFF  = 10'h112;
  localparam logic [9:0]  OFS_TX_DFE            = 10'h113;
  localparam logic [9:0]  OFS_POWER_AMP_CONFIG  = 10'h114;
  localparam logic [9:0]  OFS_STATE_STATUS      = 10'h115;
  localparam logic [9:0]  OFS_BB_IRQ_MASK       = 10'h300;
  localparam logic [9:0]  OFS_PHY_CONTROL       = 10'h301;
  localparam logic [9:0]  OFS_OFDM_CONFIG       = 10'h304;
  localparam logic [9:0]  OFS_OFDM_TX_HEADER    = 10'h30C;

  // field positions
  localparam int          PHY_TYPE_LSB   = 0;
  localparam int          OFDM_OPT_LSB   = 0;
  localparam int          MCS_LSB        = 0;
  localparam int          AGC_TGT_LSB    = 5;

  // reset values
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_AGC_CTRL   = 8'h00;
  localparam logic [7:0]  RST_AGC_TARGET = 8'h60;
  localparam logic [7:0]  RST_OFDM_CFG   = 8'h00;
  localparam logic [7:0]  RST_LFSR       = 8'hA5;
  localparam logic [15:0] RST_CHAN_NUM   = 16'h0000;
  localparam logic [15:0] RST_CFREQ      = 16'h0000;

  // physical meaning of the frequency words and field codes
  localparam int          CFREQ_STEP_KHZ = 25;
  localparam logic [7:0]  CS_CODE_1M2    = 8'h30;
  localparam logic [7:0]  EDD_CODE_960US = 8'h7A;
  localparam logic [1:0]  PHY_MR_OFDM    = 2'h2;
  localparam logic [2:0]  MCS_800K       = 3'h3;
  localparam logic [1:0]  OFDM_OPTION_1  = 2'h0;

  typedef enum logic [1:0] {
    RBC_TRX_OFF = 2'b01,
    RBC_TRX_CFG = 2'b10
  } rbc_trx_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rbc_bus_req_t;

  typedef struct packed {
    logic [15:0] center_freq_value;
    logic [7:0]  channel_spacing;
    logic [15:0] channel_number;
  } rbc_channel_t;

endpackage

// *** verification/rbc_host_model.sv ***
// Purpose: host side model issuing register bus cycles
// Assumes: one-cycle strobes, changed right after the rising edge
// Notes:   idle lines are flipped so stale values never look valid
`timescale 1ns/1ps

module rbc_host_model (
  input  wire logic             sys_clk_i,
  output rbc_pkg::rbc_bus_req_t bus_req_o
);
  import rbc_pkg::*;

  rbc_bus_req_t req_ff = '0;

  assign bus_req_o = req_ff;

  task automatic op(input logic w, input logic r, input logic [9:0] a,
                    input logic [7:0] d);
    @(posedge sys_clk_i);
    req_ff <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic idle();
    op(1'b0, 1'b0, ~req_ff.addr, ~req_ff.wdata);
  endtask

  // host orders every step itself, no embedded help
  task automatic setup();
    logic [17:0] seq [15];
    seq = '{
      {OFS_RADIO_IRQ_MASK, 8'h1F}, {OFS_BB_IRQ_MASK, 8'h1F},
      {OFS_CHANNEL_SPACING, 8'h30},
      {OFS_CENTER_FREQ_LOW, 8'h20}, {OFS_CENTER_FREQ_HIGH, 8'h8D},
      {OFS_RX_BW_CTRL, 8'h09}, {OFS_RX_DFE, 8'h83},
      {OFS_TX_FILTER_CUTOFF, 8'h0B}, {OFS_TX_DFE, 8'h83},
      {OFS_POWER_AMP_CONFIG, 8'h7C},
      {OFS_ED_DURATION, 8'h7A}, {OFS_PHY_CONTROL, 8'h56},
      {OFS_OFDM_TX_HEADER, 8'h03},
      {OFS_CHANNEL_NUM_LOW, 8'h03}, {OFS_CHANNEL_NUM_HIGH, 8'h00}
    };
    foreach (seq[i]) op(1'b1, 1'b0, seq[i][17:8], seq[i][7:0]);
    idle();
  endtask
endmodule

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the configuration bank
// Assumes: host model drives the bus, monitor pops queued expectations
// Notes:   random reads only checked for change between reads
`timescale 1ns/1ps

module tb_top;
  import rbc_pkg::*;

  logic         sys_clk = 1'b0;
  logic         resetn  = 1'b0;
  rbc_bus_req_t bus_req;
  rbc_channel_t chan;
  logic [7:0]   rdata, rad_mask, bb_mask, edd, v;
  logic [7:0]   last_rnd;
  logic         upd, trx_off;
  logic         rd_seen = 1'b0;
  logic [1:0]   phy_type, ofdm_opt;
  logic [2:0]   mcs;
  logic [8:0]   rd_q [$];
  rbc_channel_t ch_q [$];
  int           error_cnt = 0;
  int           n_tests = 0;
  int           cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  rbc_host_model i_rbc_host_model (.sys_clk_i(sys_clk), .bus_req_o(bus_req));

  rbc_config_bank i_rbc_config_bank (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .bus_req_i(bus_req),
    .rdata_o(rdata), .channel_o(chan), .channel_update_o(upd),
    .radio_irq_mask_o(rad_mask), .bb_irq_mask_o(bb_mask),
    .phy_type_o(phy_type), .coding_scheme_o(mcs),
    .ofdm_option_o(ofdm_opt), .ed_duration_o(edd),
    .transceiver_off_o(trx_off)
  );

  task automatic check(input string what, input logic [39:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // bit 8 of a note marks a random read
  task automatic rd(input logic [9:0] a, input logic [8:0] e);
    rd_q.push_back(e);
    i_rbc_host_model.op(1'b0, 1'b1, a, 8'($urandom));
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    i_rbc_host_model.op(1'b1, 1'b0, a, d);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    rd_seen <= bus_req.rd;
    if (rd_seen) begin
      if (rd_q[0][8]) begin
        check("random value", rdata !== last_rnd, 1);
        last_rnd = rdata;
      end else begin
        check("read data", rdata, rd_q[0][7:0]);
      end
      void'(rd_q.pop_front());
    end
    if (upd) begin
      if (ch_q.size() == 0) check("spurious update", 1, 0);
      else check("channel set", chan, ch_q.pop_front());
    end
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    logic [9:0] rw [17];
    logic [7:0] sh [17];
    rw = '{10'h100, 10'h104, 10'h105, 10'h106, 10'h107, 10'h109, 10'h10A,
           10'h10B, 10'h10C, 10'h10F, 10'h112, 10'h113, 10'h114, 10'h300,
           10'h301, 10'h304, 10'h30C};
    void'($urandom(32'h60F1));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    check("off after reset", trx_off, 1);
    rd(OFS_AGC_CTRL, 9'h000);
    rd(OFS_AGC_TARGET, 9'h060);
    rd(OFS_OFDM_CONFIG, 9'h000);
    rd(OFS_PHY_CONTROL, 9'h054);
    rd(OFS_STATE_STATUS, 9'h001);
    rd(OFS_RANDOM_VALUE, 9'h100);
    wr(OFS_RANDOM_VALUE, 8'h00);
    rd(OFS_RANDOM_VALUE, 9'h100);
    foreach (rw[i]) begin
      sh[i] = 8'($urandom);
      wr(rw[i], sh[i]);
    end
    wr(10'h3FF, 8'hFF);
    foreach (rw[i]) rd(rw[i], {1'b0, sh[i]});
    rd(10'h3FF, 9'h000);
    // scrub the random fill so setup starts from the reset defaults
    i_rbc_host_model.idle();
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    check("off after pulse", trx_off, 1);
    ch_q.push_back('{16'h8D20, 8'h30, 16'h0003});
    i_rbc_host_model.setup();
    repeat (3) @(posedge sys_clk);
    #1;
    check("radio mask", rad_mask, 8'h1F);
    check("bb mask", bb_mask, 8'h1F);
    check("phy type", phy_type, PHY_MR_OFDM);
    check("coding scheme", mcs, MCS_800K);
    check("ofdm option", ofdm_opt, OFDM_OPTION_1);
    check("ed duration", edd, EDD_CODE_960US);
    check("left off state", trx_off, 0);
    rd(OFS_PHY_CONTROL, 9'h056);
    rd(OFS_POWER_AMP_CONFIG, 9'h07C);
    // unchanged high byte still applies the channel
    ch_q.push_back('{16'h8D20, 8'h30, 16'h0003});
    wr(OFS_CHANNEL_NUM_HIGH, 8'h00);
    v = 8'($urandom);
    ch_q.push_back('{16'h1220, 8'h30, {8'h01, v}});
    wr(OFS_CENTER_FREQ_HIGH, 8'h12);
    wr(OFS_CHANNEL_NUM_LOW, v);
    wr(OFS_CHANNEL_NUM_HIGH, 8'h01);
    rd(OFS_CHANNEL_NUM_LOW, {1'b0, v});
    i_rbc_host_model.idle();
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("reset channel", chan, 40'h0);
    check("reset off", trx_off, 1);
    check("reset mask", rad_mask, 8'h00);
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFS_PHY_CONTROL, 9'h054);
    i_rbc_host_model.idle();
    repeat (3) @(posedge sys_clk);
    check("notes left", rd_q.size() + ch_q.size(), 0);
    tally_and_finish();
  end
endmodule
